/* common/sawt_pkg.sv */
package sawt_pkg;

	// ****************************************************************
	// bus geometry
	// ****************************************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// ****************************************************************
	// register offsets (byte addresses)
	// ****************************************************************
	localparam logic [ADDR_W-1:0] OFF_AREA2_WAIT = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_AREA3_WAIT = 8'h04;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int CAS_LO = 7;
	localparam int CAS_HI = 8;
	localparam int FIXED_ONE_BIT = 10;
	localparam int TRCD_LO = 10;
	localparam int TRCD_HI = 11;
	localparam int TRP_LO = 13;
	localparam int TRP_HI = 14;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [1:0] AREA2_CAS_RST = 2'h2;
	localparam logic [1:0] AREA3_TRP_RST = 2'h0;
	localparam logic [1:0] AREA3_TRCD_RST = 2'h0;
	localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

	// ****************************************************************
	// sdram geometry and timing widths
	// ****************************************************************
	localparam int NUM_BANKS = 4;
	localparam int BANK_W = 2;
	localparam int WAIT_W = 2;
	localparam int CAS_MAX = 4;

	// ****************************************************************
	// sequencer commands
	// ****************************************************************
	typedef enum logic [3:0] {
		CMD_NOP = 4'h0,
		CMD_ROW_ACTIVATE = 4'h1,
		CMD_COLUMN_READ = 4'h2,
		CMD_COLUMN_READ_AP = 4'h3,
		CMD_COLUMN_WRITE = 4'h4,
		CMD_COLUMN_WRITE_AP = 4'h5,
		CMD_BANK_PRECHARGE = 4'h6,
		CMD_ALL_BANK_PRECHARGE = 4'h7,
		CMD_AUTO_REFRESH = 4'h8,
		CMD_SELF_REFRESH = 4'h9,
		CMD_POWER_DOWN = 4'ha,
		CMD_DEEP_POWER_DOWN = 4'hb
	} sawt_cmd_t;

endpackage

/* rtl/sawt_wait_timer.sv */
`timescale 1ns/1ps
module sawt_wait_timer (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [sawt_pkg::WAIT_W-1:0] load_value,
	output logic busy
);
	import sawt_pkg::*;

	typedef struct packed {
		logic [WAIT_W-1:0] count;
	} sawt_timer_state_t;

	sawt_timer_state_t state_reg;
	sawt_timer_state_t state_next;

	// ****************************************************************
	// down-counter, held command waits for zero
	// ****************************************************************
	always_comb begin
		state_next = state_reg;
		if (load) begin
			state_next.count = load_value;
		end else if (state_reg.count != '0) begin
			state_next.count = state_reg.count - 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign busy = (state_reg.count != '0);

endmodule

/* rtl/sawt_cas_pipe.sv */
`timescale 1ns/1ps
module sawt_cas_pipe (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [1:0] latency_sel,
	output logic capture
);
	import sawt_pkg::*;

	typedef struct packed {
		logic [CAS_MAX-1:0] shift;
	} sawt_cas_state_t;

	sawt_cas_state_t state_reg;
	sawt_cas_state_t state_next;

	// ****************************************************************
	// token enters at latency-1, reaches bit 0 after latency cycles
	// ****************************************************************
	always_comb begin
		state_next = state_reg;
		state_next.shift = state_reg.shift >> 1;
		if (start) begin
			state_next.shift[latency_sel] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign capture = state_reg.shift[0];

endmodule

/* rtl/sawt_core.sv */
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
module sawt_core (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [sawt_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [sawt_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [sawt_pkg::DATA_W-1:0] reg_rdata,
	input wire logic cmd_valid,
	input wire sawt_pkg::sawt_cmd_t cmd_code,
	input wire logic [sawt_pkg::BANK_W-1:0] cmd_bank,
	input wire logic cmd_area3,
	output logic cmd_ready,
	output logic [1:0] cas_latency_sel,
	output logic [sawt_pkg::WAIT_W-1:0] precharge_wait_sel,
	output logic [sawt_pkg::WAIT_W-1:0] row_to_column_wait_sel,
	output logic [sawt_pkg::NUM_BANKS-1:0] bank_open,
	output logic read_capture
);
	import sawt_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [DATA_W-1:0] rdata;
		logic [1:0] cas;
		logic [WAIT_W-1:0] trp;
		logic [WAIT_W-1:0] trcd;
		logic [NUM_BANKS-1:0] open;
	} sawt_core_state_t;

	sawt_core_state_t state_reg;
	sawt_core_state_t state_next;

	logic cmd_fire;
	logic [NUM_BANKS-1:0] bank_sel;
	logic [NUM_BANKS-1:0] pre_load;
	logic [NUM_BANKS-1:0] rcd_load;
	logic [NUM_BANKS-1:0] pre_busy;
	logic [NUM_BANKS-1:0] rcd_busy;
	logic any_pre_busy;
	logic read_area2;
	logic [DATA_W-1:0] area2_view;
	logic [DATA_W-1:0] area3_view;

	// ****************************************************************
	// decoding helpers
	// ****************************************************************
	function automatic logic [WAIT_W-1:0] field_to_wait(
		input logic [1:0] field
	);
		// 00..11 map straight onto 0..3 idle cycles
		return WAIT_W'(field);
	endfunction

	function automatic logic is_column(input sawt_cmd_t code);
		return (code == CMD_COLUMN_READ) || (code == CMD_COLUMN_READ_AP) ||
			(code == CMD_COLUMN_WRITE) || (code == CMD_COLUMN_WRITE_AP);
	endfunction

	function automatic logic is_auto_pre(input sawt_cmd_t code);
		return (code == CMD_COLUMN_READ_AP) || (code == CMD_COLUMN_WRITE_AP);
	endfunction

	// ****************************************************************
	// register read views
	// ****************************************************************
	always_comb begin
		area2_view = '0;
		area2_view[FIXED_ONE_BIT] = 1'b1;
		area2_view[CAS_HI:CAS_LO] = state_reg.cas;
		area3_view = '0;
		area3_view[TRP_HI:TRP_LO] = state_reg.trp;
		area3_view[TRCD_HI:TRCD_LO] = state_reg.trcd;
	end

	// ****************************************************************
	// command acceptance
	// ****************************************************************
	assign any_pre_busy = |pre_busy;

	always_comb begin
		cmd_ready = 1'b0;
		case (cmd_code)
			CMD_NOP: begin
				cmd_ready = 1'b1;
			end
			CMD_ROW_ACTIVATE: begin
				cmd_ready = !pre_busy[cmd_bank] && !state_reg.open[cmd_bank];
			end
			CMD_COLUMN_READ, CMD_COLUMN_READ_AP,
			CMD_COLUMN_WRITE, CMD_COLUMN_WRITE_AP: begin
				cmd_ready = state_reg.open[cmd_bank] && !rcd_busy[cmd_bank];
			end
			CMD_BANK_PRECHARGE, CMD_ALL_BANK_PRECHARGE: begin
				cmd_ready = 1'b1;
			end
			CMD_AUTO_REFRESH, CMD_SELF_REFRESH: begin
				cmd_ready = !any_pre_busy && (state_reg.open == '0);
			end
			CMD_POWER_DOWN, CMD_DEEP_POWER_DOWN: begin
				cmd_ready = !any_pre_busy;
			end
			default: begin
				cmd_ready = 1'b0;
			end
		endcase
	end

	assign cmd_fire = cmd_valid && cmd_ready;

	// ****************************************************************
	// per-bank wait timers
	// ****************************************************************
	genvar b;
	generate
		for (b = 0; b < NUM_BANKS; b++) begin : g_bank
			assign bank_sel[b] = (cmd_bank == BANK_W'(b));

			// precharge or auto-precharge start, or all-bank precharge
			assign pre_load[b] = cmd_fire && (
				((cmd_code == CMD_BANK_PRECHARGE) && bank_sel[b]) ||
				(cmd_code == CMD_ALL_BANK_PRECHARGE) ||
				(is_auto_pre(cmd_code) && bank_sel[b]));

			assign rcd_load[b] = cmd_fire &&
				(cmd_code == CMD_ROW_ACTIVATE) && bank_sel[b];

			// shared value, whichever area issued the command
			sawt_wait_timer u_pre_timer (
				.clk_sys(clk_sys),
				.rst_n(rst_n),
				.load(pre_load[b]),
				.load_value(field_to_wait(state_reg.trp)),
				.busy(pre_busy[b])
			);

			sawt_wait_timer u_rcd_timer (
				.clk_sys(clk_sys),
				.rst_n(rst_n),
				.load(rcd_load[b]),
				.load_value(field_to_wait(state_reg.trcd)),
				.busy(rcd_busy[b])
			);
		end
	endgenerate

	// ****************************************************************
	// cas latency capture strobe for area 2 reads
	// ****************************************************************
	assign read_area2 = cmd_fire && !cmd_area3 &&
		((cmd_code == CMD_COLUMN_READ) || (cmd_code == CMD_COLUMN_READ_AP));

	sawt_cas_pipe u_cas_pipe (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.start(read_area2),
		.latency_sel(state_reg.cas),
		.capture(read_capture)
	);

	// ****************************************************************
	// next state: register bus and bank tracking
	// ****************************************************************
	always_comb begin
		state_next = state_reg;
		state_next.rdata = RDATA_RST;

		if (reg_wr) begin
			case (reg_addr)
				OFF_AREA2_WAIT: begin
					state_next.cas = reg_wdata[CAS_HI:CAS_LO];
				end
				OFF_AREA3_WAIT: begin
					state_next.trp = reg_wdata[TRP_HI:TRP_LO];
					state_next.trcd = reg_wdata[TRCD_HI:TRCD_LO];
				end
				default: begin
					state_next.cas = state_reg.cas;
				end
			endcase
		end

		if (reg_rd) begin
			case (reg_addr)
				OFF_AREA2_WAIT: begin
					state_next.rdata = area2_view;
				end
				OFF_AREA3_WAIT: begin
					state_next.rdata = area3_view;
				end
				default: begin
					state_next.rdata = RDATA_RST;
				end
			endcase
		end

		if (cmd_fire) begin
			if (cmd_code == CMD_ROW_ACTIVATE) begin
				state_next.open[cmd_bank] = 1'b1;
			end else if ((cmd_code == CMD_BANK_PRECHARGE) ||
				(is_column(cmd_code) && is_auto_pre(cmd_code))) begin
				state_next.open[cmd_bank] = 1'b0;
			end else if (cmd_code == CMD_ALL_BANK_PRECHARGE) begin
				state_next.open = '0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg.rdata <= RDATA_RST;
			state_reg.cas <= AREA2_CAS_RST;
			state_reg.trp <= AREA3_TRP_RST;
			state_reg.trcd <= AREA3_TRCD_RST;
			state_reg.open <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign reg_rdata = state_reg.rdata;
	assign cas_latency_sel = state_reg.cas;
	assign precharge_wait_sel = state_reg.trp;
	assign row_to_column_wait_sel = state_reg.trcd;
	assign bank_open = state_reg.open;

endmodule

/* dv/sawt_core_checker.sv */
`timescale 1ns/1ps
module sawt_core_checker (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [sawt_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [sawt_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [sawt_pkg::DATA_W-1:0] reg_rdata,
	input wire logic cmd_valid,
	input wire sawt_pkg::sawt_cmd_t cmd_code,
	input wire logic [sawt_pkg::BANK_W-1:0] cmd_bank,
	input wire logic cmd_area3,
	input wire logic cmd_ready,
	input wire logic [1:0] cas_latency_sel,
	input wire logic [sawt_pkg::WAIT_W-1:0] precharge_wait_sel,
	input wire logic [sawt_pkg::WAIT_W-1:0] row_to_column_wait_sel,
	input wire logic [sawt_pkg::NUM_BANKS-1:0] bank_open,
	input wire logic read_capture
);
	import sawt_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic take;
	logic act;
	logic col;
	logic dep;
	assign take = cmd_valid && cmd_ready;
	assign act = take && cmd_code == CMD_ROW_ACTIVATE;
	assign col = take && cmd_code inside {CMD_COLUMN_READ,
		CMD_COLUMN_READ_AP, CMD_COLUMN_WRITE, CMD_COLUMN_WRITE_AP};
	assign dep = take && cmd_code inside {CMD_ROW_ACTIVATE, CMD_AUTO_REFRESH,
		CMD_SELF_REFRESH, CMD_POWER_DOWN, CMD_DEEP_POWER_DOWN};
	a_fixed_bits: assert property (
		reg_rd && reg_addr == OFF_AREA2_WAIT |=> reg_rdata[31:11] == 21'h0
		&& reg_rdata[10] && !reg_rdata[9] && reg_rdata[6:0] == 7'h0)
		else $error("area2 fixed bits wrong");
	a_cas_readback: assert property (
		reg_rd && reg_addr == OFF_AREA2_WAIT |=>
		reg_rdata[8:7] == cas_latency_sel) else $error("cas readback");
	a_cas_write: assert property (
		reg_wr && reg_addr == OFF_AREA2_WAIT |=>
		cas_latency_sel == $past(reg_wdata[8:7])) else $error("cas write");
	a_area3_read: assert property (
		reg_rd && reg_addr == OFF_AREA3_WAIT |=> reg_rdata == {17'h0,
		precharge_wait_sel, 1'b0, row_to_column_wait_sel, 10'h0})
		else $error("area3 readback");
	a_trcd_hold: assert property (
		act && row_to_column_wait_sel == 2'h3 |=> !col [*3])
		else $error("column too early");
	a_trp_hold: assert property (
		take && cmd_code == CMD_ALL_BANK_PRECHARGE
		&& precharge_wait_sel == 2'h3 |=> !dep [*3])
		else $error("precharge wait broken");
	a_cas_lat: assert property (
		take && cmd_code == CMD_COLUMN_READ && !cmd_area3
		&& cas_latency_sel == 2'h2 |-> ##3 read_capture)
		else $error("capture late");
	a_rdata_idle: assert property (
		!reg_rd |=> reg_rdata == 32'h0) else $error("rdata not idle");
	a_act_opens: assert property (
		act |=> bank_open[$past(cmd_bank)]) else $error("bank not open");
endmodule

/* dv/sawt_sdram_model.sv */
`timescale 1ns/1ps
module sawt_sdram_model (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic take,
	input wire sawt_pkg::sawt_cmd_t cmd_code,
	input wire logic [1:0] cmd_bank,
	output int n_err
);
	import sawt_pkg::*;
	logic [3:0] open_reg;
	// flags commands that a real device would reject
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			open_reg <= 4'h0;
			n_err <= 0;
		end else if (take) begin
			case (cmd_code)
				CMD_ROW_ACTIVATE: begin
					n_err <= n_err + int'(open_reg[cmd_bank]);
					open_reg[cmd_bank] <= 1'b1;
				end
				CMD_COLUMN_READ, CMD_COLUMN_WRITE: begin
					n_err <= n_err + int'(!open_reg[cmd_bank]);
				end
				CMD_COLUMN_READ_AP, CMD_COLUMN_WRITE_AP: begin
					n_err <= n_err + int'(!open_reg[cmd_bank]);
					open_reg[cmd_bank] <= 1'b0;
				end
				CMD_BANK_PRECHARGE: open_reg[cmd_bank] <= 1'b0;
				CMD_ALL_BANK_PRECHARGE: open_reg <= 4'h0;
				CMD_AUTO_REFRESH, CMD_SELF_REFRESH: begin
					n_err <= n_err + int'(open_reg != 4'h0);
				end
				default: ;
			endcase
		end
	end
endmodule

/* dv/sdram_area_wait_timing_tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
	$display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module sdram_area_wait_timing_tb_top;
	import sawt_pkg::*;
	logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
	logic cmd_valid = 0, cmd_area3 = 0, cmd_ready, read_capture;
	logic [7:0] reg_addr = 0;
	logic [31:0] reg_wdata = 0, reg_rdata;
	sawt_cmd_t cmd_code = CMD_NOP;
	logic [1:0] cmd_bank = 0, cas_sel, trp_sel, trcd_sel;
	logic [3:0] bank_open;
	int n_fail = 0, samples_checked = 0, cyc = 0, n_err;
	sawt_cmd_t fol[3] = '{CMD_AUTO_REFRESH, CMD_SELF_REFRESH,
		CMD_DEEP_POWER_DOWN};
	always #50 clk_sys = ~clk_sys;
	sawt_core sawt_core_inst (.clk_sys(clk_sys), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_bank(cmd_bank), .cmd_area3(cmd_area3),
		.cmd_ready(cmd_ready), .cas_latency_sel(cas_sel),
		.precharge_wait_sel(trp_sel), .row_to_column_wait_sel(trcd_sel),
		.bank_open(bank_open), .read_capture(read_capture));
	sawt_sdram_model sawt_sdram_model_inst (.clk_sys(clk_sys), .rst_n(rst_n),
		.take(cmd_valid && cmd_ready), .cmd_code(cmd_code),
		.cmd_bank(cmd_bank), .n_err(n_err));
	task automatic tally_and_finish;
		if (n_fail == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		`CHK(reg_rdata, e)
		@(posedge clk_sys);
	endtask
	// offer a command, count cycles refused, return at the taking edge
	task automatic issue(input sawt_cmd_t c, input logic [1:0] b,
		input logic a3, output int n);
		n = 0;
		cmd_code <= c;
		cmd_bank <= b;
		cmd_area3 <= a3;
		cmd_valid <= 1'b1;
		@(negedge clk_sys);
		while (cmd_ready !== 1'b1) begin
			n++;
			@(negedge clk_sys);
		end
		@(posedge clk_sys);
	endtask
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	initial begin
		int n, k;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		rd(OFF_AREA2_WAIT, 32'h0000_0500);
		rd(OFF_AREA3_WAIT, 32'h0);
		wr(OFF_AREA2_WAIT, 32'hffff_ffff);
		rd(OFF_AREA2_WAIT, 32'h0000_0580);
		wr(8'h08, 32'hffff_ffff);
		rd(8'h08, 32'h0);
		rd(OFF_AREA3_WAIT, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(OFF_AREA2_WAIT, 32'(i << 7));
			rd(OFF_AREA2_WAIT, 32'h400 | 32'(i << 7));
			wr(OFF_AREA3_WAIT, 32'((i << 13) | (i << 10)));
			rd(OFF_AREA3_WAIT, 32'((i << 13) | (i << 10)));
			issue(CMD_ROW_ACTIVATE, 2'h0, 1'(i), n);
			issue(CMD_COLUMN_READ, 2'h0, 1'b0, n);
			`CHK(n, i)
			cmd_valid <= 1'b0;
			k = 0;
			for (int j = 1; j <= 5; j++) begin
				@(negedge clk_sys);
				if (read_capture === 1'b1) k = j;
			end
			@(posedge clk_sys);
			`CHK(k, i + 1)
			issue(CMD_ALL_BANK_PRECHARGE, 2'h0, 1'b0, n);
			issue(CMD_ROW_ACTIVATE, 2'h1, 1'b1, n);
			`CHK(n, i)
			issue(CMD_COLUMN_WRITE_AP, 2'h1, 1'b1, n);
			issue(CMD_ROW_ACTIVATE, 2'h1, 1'b0, n);
			`CHK(n, i)
			issue(CMD_BANK_PRECHARGE, 2'h1, 1'b0, n);
			issue(CMD_POWER_DOWN, 2'h0, 1'b0, n);
			`CHK(n, i)
			for (int j = 0; j < 3; j++) begin
				issue(CMD_ALL_BANK_PRECHARGE, 2'h0, 1'b0, n);
				issue(fol[j], 2'h0, 1'b0, n);
				`CHK(n, i)
			end
			cmd_valid <= 1'b0;
		end
		`CHK(n_err, 0)
		tally_and_finish();
	end
endmodule
bind sawt_core sawt_core_checker sawt_core_checker_inst (
	.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
	.cmd_bank(cmd_bank), .cmd_area3(cmd_area3), .cmd_ready(cmd_ready),
	.cas_latency_sel(cas_latency_sel), .precharge_wait_sel(precharge_wait_sel),
	.row_to_column_wait_sel(row_to_column_wait_sel), .bank_open(bank_open),
	.read_capture(read_capture));
